// file: design/rpmt_map.vh
// Constants for the servo-pulse motion target block: timing, limits and reset values
`ifndef RPMT_MAP_VH
`define RPMT_MAP_VH

// ****************************************************************
// Timing
// ****************************************************************
`define RPMT_CLK_PERIOD_NS  10
`define RPMT_TICK_NS        1000
`define RPMT_TICK_CYC       (`RPMT_TICK_NS / `RPMT_CLK_PERIOD_NS)

// ****************************************************************
// Accepted servo pulse widths and width counter saturation, microseconds
// ****************************************************************
`define RPMT_PULSE_MIN_US   12'h1F4
`define RPMT_PULSE_MAX_US   12'h9C4
`define RPMT_WIDTH_SAT      12'hFFF

// ****************************************************************
// Scaling arithmetic
// ****************************************************************
`define RPMT_FRAC_BITS      16
`define RPMT_ONE            17'h10000
`define RPMT_DIV_STEPS      5'h1C

// ****************************************************************
// Configuration reset values
// ****************************************************************
`define RPMT_INMAX_RST      12'h7D0
`define RPMT_NMAX_RST       12'h60E
`define RPMT_NMIN_RST       12'h5AA
`define RPMT_INMIN_RST      12'h3E8
`define RPMT_TMAX_RST       32'h000000C8
`define RPMT_TMIN_RST       32'hFFFFFF38
`define RPMT_DEG_RST        3'h1

`endif

// file: design/rpmt_top.v
// Servo pulse to stepper motion target: scaling, neutral band, safe start, relearn and fault line
//
// Operation
// RL1: The fault line output is driven high while this device has an error of its own and low otherwise.
// RL2: A high level sensed on the fault line is an error unless the ignore-fault-high setting is set.
// RL3: In position mode after reset no target is issued until a valid pulse arrives, which is then learned as current position.
// RL4: Any error marks the position uncertain, and it is relearned from the next valid pulse once the error is gone.
// RL5: In position mode neutral maps to 0, the input maximum to the target maximum and the input minimum to the target minimum.
// RL6: Scaling uses input maximum, neutral upper and lower bounds, input minimum and an inversion flag that swaps the extremes.
// RL7: Target maximum resets to 200 and target minimum to -200.
// RL8: The configuring party keeps target maximum at or above zero and target minimum at or below zero.
// RL9: In speed mode neutral maps to velocity 0, the maximum input to target maximum and the minimum to target minimum.
// RL10: With safe start enabled the motor stays de-energized and a violation is flagged until the input has been neutral; code clears the flag during errors.
// RL11: Scaling degree resets to 1 (linear); higher degrees raise the input fraction to that power.
// RL12: Motor direction inversion negates the issued target.
// RL13: Inputs between the neutral bounds give exactly zero and count as neutral for safe start.
`timescale 1ns/1ps
`default_nettype none
`include "rpmt_map.vh"

module rpmt_top #(
    // Clock cycles per microsecond tick, 2 to 128; a bench may shorten it to keep runs brief
    parameter integer TICK_CYC = `RPMT_TICK_CYC
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // Pins
    input  wire        servo_pulse_input,
    input  wire        fault_line_in,
    output reg         fault_line_out_r,
    // Own error source, same clock
    input  wire        err_condition,
    // Configuration
    input  wire        cfg_wr,
    input  wire        cfg_speed_mode,
    input  wire [11:0] cfg_input_max,
    input  wire [11:0] cfg_neutral_max,
    input  wire [11:0] cfg_neutral_min,
    input  wire [11:0] cfg_input_min,
    input  wire        cfg_invert_input,
    input  wire [31:0] cfg_target_max,
    input  wire [31:0] cfg_target_min,
    input  wire [2:0]  cfg_scaling_degree,
    input  wire        cfg_invert_motor,
    input  wire        cfg_safe_start_off,
    input  wire        cfg_ignore_fault_high,
    // Motion target and status
    output reg  [31:0] motion_target_r,
    output reg         target_strobe_r,
    output reg         learn_position_r,
    output reg         motor_energized_r,
    output reg         safe_start_viol_r,
    output reg         pos_uncertain_r,
    output reg         error_active_r
);

    localparam integer TICK_LAST_I = TICK_CYC - 1;
    localparam [6:0]   TICK_LAST   = TICK_LAST_I[6:0];

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_DIV  = 5'h02;
    localparam [4:0] ST_POW  = 5'h04;
    localparam [4:0] ST_MUL  = 5'h08;
    localparam [4:0] ST_OUT  = 5'h10;

    // Distance beyond a neutral bound, clamped to the span
    function [11:0] dist_clamp;
        input [11:0] far;
        input [11:0] near;
        input [11:0] span;
        reg   [11:0] d;
        begin
            d = far - near;
            dist_clamp = (d > span) ? span : d;
        end
    endfunction

    // ****************************************************************
    // Configuration
    // ****************************************************************
    reg        speed_mode_r;
    reg [11:0] input_max_r;
    reg [11:0] neutral_max_r;
    reg [11:0] neutral_min_r;
    reg [11:0] input_min_r;
    reg        invert_input_r;
    reg [31:0] target_max_r;
    reg [31:0] target_min_r;
    reg [2:0]  degree_r;
    reg        invert_motor_r;
    reg        safe_off_r;
    reg        ignore_fault_r;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            speed_mode_r   <= 1'b0;
            input_max_r    <= `RPMT_INMAX_RST;
            neutral_max_r  <= `RPMT_NMAX_RST;
            neutral_min_r  <= `RPMT_NMIN_RST;
            input_min_r    <= `RPMT_INMIN_RST;
            invert_input_r <= 1'b0;
            target_max_r   <= `RPMT_TMAX_RST; // RL7
            target_min_r   <= `RPMT_TMIN_RST; // RL7
            degree_r       <= `RPMT_DEG_RST; // RL11
            invert_motor_r <= 1'b0;
            safe_off_r     <= 1'b0;
            ignore_fault_r <= 1'b0; // RL2
        end else if (cfg_wr) begin
            speed_mode_r   <= cfg_speed_mode;
            input_max_r    <= cfg_input_max;
            neutral_max_r  <= cfg_neutral_max;
            neutral_min_r  <= cfg_neutral_min;
            input_min_r    <= cfg_input_min;
            invert_input_r <= cfg_invert_input;
            target_max_r   <= cfg_target_max;
            target_min_r   <= cfg_target_min;
            degree_r       <= cfg_scaling_degree;
            invert_motor_r <= cfg_invert_motor;
            safe_off_r     <= cfg_safe_start_off;
            ignore_fault_r <= cfg_ignore_fault_high;
        end
    end

    // ****************************************************************
    // Pin synchronisers and microsecond tick
    // ****************************************************************
    reg [2:0] pulse_sync_r;
    reg [2:0] fault_sync_r;
    reg       pulse_f_r;
    reg       fault_f_r;
    reg [6:0] div_cnt_r;
    reg       tick_r;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pulse_sync_r <= 3'h0;
            fault_sync_r <= 3'h0;
            pulse_f_r    <= 1'b0;
            fault_f_r    <= 1'b0;
            div_cnt_r    <= 7'h00;
            tick_r       <= 1'b0;
        end else begin
            pulse_sync_r <= {pulse_sync_r[1:0], servo_pulse_input};
            fault_sync_r <= {fault_sync_r[1:0], fault_line_in};
            if (pulse_sync_r[1] == pulse_sync_r[2]) begin
                pulse_f_r <= pulse_sync_r[2];
            end
            if (fault_sync_r[1] == fault_sync_r[2]) begin
                fault_f_r <= fault_sync_r[2];
            end
            tick_r    <= (div_cnt_r == TICK_LAST);
            div_cnt_r <= (div_cnt_r == TICK_LAST) ? 7'h00 : div_cnt_r + 7'h01;
        end
    end

    // ****************************************************************
    // Pulse width measurement
    // ****************************************************************
    reg        pulse_d_r;
    reg [11:0] width_cnt_r;
    reg [11:0] width_r;
    reg        width_ok_r;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pulse_d_r   <= 1'b0;
            width_cnt_r <= 12'h000;
            width_r     <= 12'h000;
            width_ok_r  <= 1'b0;
        end else begin
            pulse_d_r  <= pulse_f_r;
            width_ok_r <= 1'b0;
            if (pulse_f_r && !pulse_d_r) begin
                width_cnt_r <= 12'h000;
            end else if (pulse_f_r && tick_r && width_cnt_r != `RPMT_WIDTH_SAT) begin
                width_cnt_r <= width_cnt_r + 12'h001;
            end
            // Out-of-range pulses are dropped so glitches never become targets
            if (!pulse_f_r && pulse_d_r) begin
                width_r    <= width_cnt_r;
                width_ok_r <= (width_cnt_r >= `RPMT_PULSE_MIN_US) && (width_cnt_r <= `RPMT_PULSE_MAX_US);
            end
        end
    end

    // ****************************************************************
    // Scaling engine
    // ****************************************************************
    wire        above_w  = width_r > neutral_max_r;
    wire        below_w  = width_r < neutral_min_r;
    wire [11:0] span_up  = input_max_r - neutral_max_r;
    wire [11:0] span_dn  = neutral_min_r - input_min_r;

    reg [4:0]  state_r;
    reg        upper_r;
    reg        neutral_r;
    reg [11:0] span_r;
    reg [27:0] dividend_r;
    reg [12:0] rem_r;
    reg [16:0] quo_r;
    reg [4:0]  step_r;
    reg [16:0] base_r;
    reg [16:0] frac_r;
    reg [2:0]  pow_cnt_r;
    reg [31:0] result_r;

    wire [12:0] rem_sh   = {rem_r[11:0], dividend_r[27]};
    wire        rem_ge   = rem_sh >= {1'b0, span_r};
    // A zero span means the bound is the extreme, so any move is full scale
    wire [16:0] quo_fin  = (span_r == 12'h000) ? `RPMT_ONE : {quo_r[15:0], rem_ge};
    wire [33:0] pow_prod = frac_r * base_r;
    // Extremes are swapped by the input inversion flag
    wire [31:0] tgt_sel  = (upper_r ^ invert_input_r) ? target_max_r : target_min_r; // RL6 RL5 RL9
    wire signed [49:0] mul_prod = $signed(tgt_sel) * $signed({1'b0, frac_r});

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r    <= ST_IDLE;
            upper_r    <= 1'b0;
            neutral_r  <= 1'b0;
            span_r     <= 12'h000;
            dividend_r <= 28'h0000000;
            rem_r      <= 13'h0000;
            quo_r      <= 17'h00000;
            step_r     <= 5'h00;
            base_r     <= 17'h00000;
            frac_r     <= 17'h00000;
            pow_cnt_r  <= 3'h0;
            result_r   <= 32'h00000000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (width_ok_r) begin
                        upper_r    <= above_w;
                        neutral_r  <= !above_w && !below_w;
                        span_r     <= above_w ? span_up : span_dn;
                        dividend_r <= {(above_w ? dist_clamp(width_r, neutral_max_r, span_up)
                                                : dist_clamp(neutral_min_r, width_r, span_dn)), 16'h0000}; // RL6
                        rem_r      <= 13'h0000;
                        quo_r      <= 17'h00000;
                        step_r     <= `RPMT_DIV_STEPS;
                        if (!above_w && !below_w) begin
                            result_r <= 32'h00000000; // RL13 RL5 RL9
                            state_r  <= ST_OUT;
                        end else begin
                            state_r  <= ST_DIV;
                        end
                    end
                end
                ST_DIV: begin
                    rem_r      <= rem_ge ? rem_sh - {1'b0, span_r} : rem_sh;
                    quo_r      <= {quo_r[15:0], rem_ge};
                    dividend_r <= {dividend_r[26:0], 1'b0};
                    step_r     <= step_r - 5'h01;
                    if (step_r == 5'h01) begin
                        // Seed the power loop with the finished quotient, never a stale one
                        base_r  <= quo_fin;
                        frac_r  <= quo_fin;
                        state_r <= ST_POW;
                    end
                    pow_cnt_r <= (degree_r > 3'h1) ? degree_r - 3'h1 : 3'h0;
                end
                ST_POW: begin
                    if (pow_cnt_r == 3'h0) begin
                        state_r <= ST_MUL;
                    end else begin
                        frac_r    <= pow_prod[32:16]; // RL11
                        pow_cnt_r <= pow_cnt_r - 3'h1;
                    end
                end
                ST_MUL: begin
                    result_r <= mul_prod[47:16];
                    state_r  <= ST_OUT;
                end
                ST_OUT: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Error, relearn, safe start and outputs
    // ****************************************************************
    wire error_now = err_condition || (fault_f_r && !ignore_fault_r); // RL2
    reg  safe_ok_r;
    reg  pulse_seen_r;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            fault_line_out_r  <= 1'b0;
            error_active_r    <= 1'b0;
            pos_uncertain_r   <= 1'b1;
            safe_ok_r         <= 1'b0;
            pulse_seen_r      <= 1'b0;
            motion_target_r   <= 32'h00000000;
            target_strobe_r   <= 1'b0;
            learn_position_r  <= 1'b0;
            motor_energized_r <= 1'b0;
            safe_start_viol_r <= 1'b0;
        end else begin
            // Only own errors drive the line, otherwise a sensed high would latch every device forever
            fault_line_out_r <= err_condition; // RL1
            error_active_r   <= error_now;
            target_strobe_r  <= 1'b0;
            learn_position_r <= 1'b0;
            if (error_now) begin
                pos_uncertain_r <= 1'b1; // RL4
                safe_ok_r       <= 1'b0; // RL10
            end else if (state_r == ST_OUT) begin
                pulse_seen_r    <= 1'b1;
                motion_target_r <= invert_motor_r ? 32'h00000000 - result_r : result_r; // RL12
                target_strobe_r <= 1'b1;
                if (neutral_r) begin
                    safe_ok_r <= 1'b1; // RL13 RL10
                end
                if (!speed_mode_r && pos_uncertain_r) begin
                    learn_position_r <= 1'b1; // RL3 RL4
                    pos_uncertain_r  <= 1'b0;
                end
            end
            motor_energized_r <= !error_now && pulse_seen_r && (safe_off_r || safe_ok_r)
                                 && (speed_mode_r || !pos_uncertain_r); // RL10 RL3
            safe_start_viol_r <= !error_now && !safe_off_r && !safe_ok_r; // RL10
        end
    end

endmodule
`default_nettype wire

// file: testbench/rpmt_props.sv
// Concurrent checks on the ports of the servo pulse motion target block
`timescale 1ns/1ps
`default_nettype none
module rpmt_props (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // Inputs watched
    input wire logic        fault_line_in,
    input wire logic        err_condition,
    // Outputs watched
    input wire logic        fault_line_out_r,
    input wire logic [31:0] motion_target_r,
    input wire logic        target_strobe_r,
    input wire logic        learn_position_r,
    input wire logic        motor_energized_r,
    input wire logic        safe_start_viol_r,
    input wire logic        pos_uncertain_r,
    input wire logic        error_active_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_fault_hi;  err_condition |=> fault_line_out_r; endproperty
    property p_fault_lo;  !err_condition |=> !fault_line_out_r; endproperty
    // Filter latency stays well inside eight quiet cycles
    property p_quiet;     (!fault_line_in && !err_condition) [*8] |-> !error_active_r; endproperty
    property p_err_state; error_active_r |-> pos_uncertain_r && !motor_energized_r; endproperty
    property p_err_drop;  error_active_r |-> !target_strobe_r; endproperty
    property p_learn;     learn_position_r |-> target_strobe_r ##1 !learn_position_r; endproperty
    property p_strobe;    target_strobe_r |=> !target_strobe_r; endproperty
    property p_viol;      safe_start_viol_r |-> !motor_energized_r; endproperty
    property p_hold;      !target_strobe_r |-> $stable(motion_target_r); endproperty
    a_fault_hi:  assert property (p_fault_hi) else $error("fault line not driven on own error");
    a_fault_lo:  assert property (p_fault_lo) else $error("fault line driven without error");
    a_quiet:     assert property (p_quiet) else $error("error reported with quiet sources");
    a_err_state: assert property (p_err_state) else $error("error did not de-energize");
    a_err_drop:  assert property (p_err_drop) else $error("target issued during error");
    a_learn:     assert property (p_learn) else $error("learn pulse not with strobe");
    a_strobe:    assert property (p_strobe) else $error("strobe longer than one cycle");
    a_viol:      assert property (p_viol) else $error("energized with safe start violation");
    a_hold:      assert property (p_hold) else $error("target changed without strobe");
    c_learn:     cover property (learn_position_r);
    c_energize:  cover property ($rose(motor_energized_r));
    c_error:     cover property (error_active_r && fault_line_out_r);
endmodule

bind rpmt_top rpmt_props u_props (.clk_sys, .rst_n, .fault_line_in, .err_condition, .fault_line_out_r,
    .motion_target_r, .target_strobe_r, .learn_position_r, .motor_energized_r, .safe_start_viol_r,
    .pos_uncertain_r, .error_active_r);
`default_nettype wire

// file: testbench/rpmt_rx_model.sv
// Servo receiver model: one pulse of the requested width, then an idle gap
`timescale 1ns/1ps
`default_nettype none
module rpmt_rx_model #(
    parameter int CYC_PER_US = 100
) (
    // Clock
    input  wire logic        clk_sys,
    // Request
    input  wire logic        send,
    input  wire logic [11:0] width_us,
    // Servo line and status
    output var  logic        pulse,
    output var  logic        busy
);
    int n;
    // Line idles low between frames; gap leaves room for the block to answer
    initial begin
        pulse = 1'b0;
        busy  = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (send) begin
                busy = 1'b1;
                n    = width_us * CYC_PER_US;
                #1 pulse = 1'b1;
                repeat (n) @(posedge clk_sys);
                #1 pulse = 1'b0;
                repeat (300) @(posedge clk_sys);
                busy = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/rpmt_tb_top.sv
// Self-checking testbench for the servo pulse motion target block
`timescale 1ns/1ps
`default_nettype none
module rpmt_tb_top;
    typedef struct {
        logic [11:0] w;
        logic        spd;
        logic        inv_in;
        logic        inv_mot;
        logic [2:0]  deg;
        logic [31:0] exp;
    } rpmt_row_t;
    // A two-cycle tick keeps twenty pulses near 71k cycles; the real tick rate goes untested
    localparam int TICK  = 2;
    localparam int LIMIT = 90000;
    logic        clk_sys, rst_n, send, pulse, busy, err_condition, fault_line_in, cfg_wr;
    logic        cfg_speed_mode, cfg_invert_input, cfg_invert_motor, cfg_safe_start_off, cfg_ignore_fault_high;
    logic [11:0] width, cfg_input_max, cfg_neutral_max, cfg_neutral_min, cfg_input_min;
    logic [31:0] cfg_target_max, cfg_target_min, motion_target_r, tgt;
    logic [2:0]  cfg_scaling_degree;
    logic        fault_line_out_r, target_strobe_r, learn_position_r, motor_energized_r;
    logic        safe_start_viol_r, pos_uncertain_r, error_active_r, got, lrn;
    int          n_mismatch, compares, cyc;
    rpmt_row_t   rows [11];

    rpmt_rx_model #(.CYC_PER_US(TICK)) u_rx (.clk_sys(clk_sys), .send(send), .width_us(width), .pulse(pulse),
        .busy(busy));
    rpmt_top #(.TICK_CYC(TICK)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .servo_pulse_input(pulse),
        .fault_line_in(fault_line_in),
        .fault_line_out_r(fault_line_out_r), .err_condition(err_condition), .cfg_wr(cfg_wr),
        .cfg_speed_mode(cfg_speed_mode), .cfg_input_max(cfg_input_max), .cfg_neutral_max(cfg_neutral_max),
        .cfg_neutral_min(cfg_neutral_min), .cfg_input_min(cfg_input_min), .cfg_invert_input(cfg_invert_input),
        .cfg_target_max(cfg_target_max), .cfg_target_min(cfg_target_min), .cfg_scaling_degree(cfg_scaling_degree),
        .cfg_invert_motor(cfg_invert_motor), .cfg_safe_start_off(cfg_safe_start_off),
        .cfg_ignore_fault_high(cfg_ignore_fault_high), .motion_target_r(motion_target_r),
        .target_strobe_r(target_strobe_r), .learn_position_r(learn_position_r),
        .motor_energized_r(motor_energized_r), .safe_start_viol_r(safe_start_viol_r),
        .pos_uncertain_r(pos_uncertain_r), .error_active_r(error_active_r));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %0d seen %0d", nm, $signed(e), $signed(g));
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic set_cfg(input logic spd, ii, im, input logic [2:0] dg, input logic [31:0] tmx, tmn,
                           input logic so, ig);
        cfg_speed_mode = spd; cfg_invert_input = ii; cfg_invert_motor = im; cfg_scaling_degree = dg;
        cfg_target_max = tmx; cfg_target_min = tmn; cfg_safe_start_off = so; cfg_ignore_fault_high = ig;
        cfg_wr = 1'b1;
        @(negedge clk_sys);
        cfg_wr = 1'b0;
    endtask
    // Sends one pulse and catches the one-cycle strobe during the idle gap
    task automatic send_pulse(input logic [11:0] w);
        got = 1'b0;
        lrn = 1'b0;
        send = 1'b1;
        width = w;
        @(negedge clk_sys);
        send = 1'b0;
        while (busy !== 1'b0) begin
            @(negedge clk_sys);
            if (target_strobe_r === 1'b1) begin
                got = 1'b1;
                lrn = learn_position_r;
                tgt = motion_target_r;
            end
        end
    endtask

    // ****************************************************************
    // Clock, timeout and sequence
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            end_of_test;
        end
    end
    initial begin
        rst_n = 1'b0; send = 1'b0; width = 12'h5DC; err_condition = 1'b0; fault_line_in = 1'b0; cfg_wr = 1'b0;
        cfg_speed_mode = 1'b0; cfg_invert_input = 1'b0; cfg_invert_motor = 1'b0; cfg_safe_start_off = 1'b0;
        cfg_ignore_fault_high = 1'b0; cfg_target_max = 32'h2D; cfg_target_min = 32'hFFFFFFD3;
        cfg_scaling_degree = 3'h1;
        cfg_input_max = 12'h7D0;
        cfg_neutral_max = 12'h60E;
        cfg_neutral_min = 12'h5AA;
        cfg_input_min = 12'h3E8;
        rows = '{'{12'h6EF, 0, 0, 0, 3'h1, 32'h16}, '{12'h4C9, 0, 0, 0, 3'h1, 32'hFFFFFFE9},
                 '{12'h6EF, 0, 1, 0, 3'h1, 32'hFFFFFFE9}, '{12'h4C9, 0, 1, 0, 3'h1, 32'h16},
                 '{12'h6EF, 0, 0, 1, 3'h1, 32'hFFFFFFEA}, '{12'h6EF, 0, 0, 0, 3'h2, 32'hB},
                 '{12'h6EF, 0, 0, 0, 3'h3, 32'h5}, '{12'h6EF, 0, 0, 0, 3'h0, 32'h16},
                 '{12'h5B4, 0, 0, 0, 3'h1, 32'h0}, '{12'h4C9, 1, 0, 0, 3'h1, 32'hFFFFFFE9},
                 '{12'h834, 1, 0, 0, 3'h1, 32'h2D}};
        repeat (2) @(negedge clk_sys);
        chk_bit("uncertain at reset", 1'b1, pos_uncertain_r);
        chk_bit("energized at reset", 1'b0, motor_energized_r);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk_bit("violation after reset", 1'b1, safe_start_viol_r);
        // Reset configuration: neutral first, then both clamped extremes
        send_pulse(12'h5DC);
        chk_bit("learn", 1'b1, lrn);
        chk_val("neutral target", 32'h0, tgt);
        chk_bit("energized", 1'b1, motor_energized_r);
        send_pulse(12'h834);
        chk_val("default max", 32'hC8, tgt);
        send_pulse(12'h384);
        chk_val("default min", 32'hFFFFFF38, tgt);
        // Targets of 45 keep each result clear of the one-microsecond count slack
        foreach (rows[i]) begin
            set_cfg(rows[i].spd, rows[i].inv_in, rows[i].inv_mot, rows[i].deg, 32'h2D, 32'hFFFFFFD3, 0, 0);
            send_pulse(rows[i].w);
            chk_bit("strobe", 1'b1, got);
            chk_val("target", rows[i].exp, tgt);
        end
        set_cfg(0, 0, 0, 3'h1, 32'h2D, 32'hFFFFFFD3, 0, 0);
        err_condition = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk_bit("fault out", 1'b1, fault_line_out_r);
        chk_bit("uncertain on error", 1'b1, pos_uncertain_r);
        send_pulse(12'h6EF);
        chk_bit("strobe during error", 1'b0, got);
        err_condition = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk_bit("fault out cleared", 1'b0, fault_line_out_r);
        send_pulse(12'h6EF);
        chk_bit("energized off-neutral", 1'b0, motor_energized_r);
        chk_bit("violation off-neutral", 1'b1, safe_start_viol_r);
        fault_line_in = 1'b1;
        repeat (10) @(negedge clk_sys);
        chk_bit("sensed fault", 1'b1, error_active_r);
        chk_bit("fault out not echoed", 1'b0, fault_line_out_r);
        fault_line_in = 1'b0;
        repeat (10) @(negedge clk_sys);
        set_cfg(0, 0, 0, 3'h1, 32'h2D, 32'hFFFFFFD3, 0, 1);
        fault_line_in = 1'b1;
        repeat (10) @(negedge clk_sys);
        chk_bit("ignored fault", 1'b0, error_active_r);
        fault_line_in = 1'b0;
        set_cfg(0, 0, 0, 3'h1, 32'h2D, 32'hFFFFFFD3, 1, 0);
        send_pulse(12'h6EF);
        chk_bit("relearn", 1'b1, lrn);
        chk_val("relearn target", 32'h16, tgt);
        chk_bit("energized safe start off", 1'b1, motor_energized_r);
        // Moved bounds: 1580 falls inside the new band, spans shrink to 300
        cfg_input_max = 12'h76C;
        cfg_neutral_max = 12'h640;
        cfg_neutral_min = 12'h578;
        cfg_input_min = 12'h44C;
        set_cfg(0, 0, 0, 3'h1, 32'h2D, 32'hFFFFFFD3, 1, 0);
        send_pulse(12'h62C);
        chk_val("inside moved band", 32'h0, tgt);
        send_pulse(12'h6D6);
        chk_val("upper moved span", 32'h16, tgt);
        send_pulse(12'h4E2);
        chk_val("lower moved span", 32'hFFFFFFE9, tgt);
        end_of_test;
    end
endmodule
`default_nettype wire
